/* File: rtl/rws_top.sv */
// Purpose: Reset, wake indicator and strap control for an Ethernet controller
// Assumes: SYS_CLK at 50 MHz, straps and pins synchronous except the external reset
// Notes:   Registers reached over APB; host write cycle means an APB write access
//
// Contract
// - Fixed reference clock times all logic
// - External reset low resets all state
// - Power-on reset covers floating external reset
// - Writes ignored until one read done
// - Enabled wake event asserts indicator
// - Software sets indicator polarity, driver type
// - Only host write wakes the device
// - Any write data wakes when sleeping
// - Crossover strap high enables auto crossover
// - Speed strap captured at reset release
// - Strap selects 10 half or 100 auto
//
// The implementer's own choices: register access over APB and the placing of the registers.
`default_nettype none

module rws_top (
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              SYS_RST,
    // External reset pin
    input  wire logic              EXTERNAL_RESET_IN_N,
    // Straps
    input  wire logic              SPEED_STRAP_IN,
    input  wire logic              CROSSOVER_AUTO_STRAP,
    // Wake event from the rest of the chip
    input  wire logic              WAKE_EVENT_IN,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Wake indicator pin
    output logic                   WAKE_INDICATOR_OUT_O,
    output logic                   WAKE_INDICATOR_OUT_OE,
    // Status towards the rest of the chip
    output logic                   INTERNAL_RESET,
    output logic                   POWER_SAVE,
    output rws_pkg::rws_link_s     LINK_CFG
);

    // =====================================================================
    // Address decode
    function automatic rws_pkg::rws_sel_e reg_sel(input logic [7:0] a);
        case (a)
            rws_pkg::OFF_ORDER:  reg_sel = rws_pkg::SEL_ORDER;
            rws_pkg::OFF_CTRL:   reg_sel = rws_pkg::SEL_CTRL;
            rws_pkg::OFF_STATUS: reg_sel = rws_pkg::SEL_STATUS;
            default:             reg_sel = rws_pkg::SEL_NONE;
        endcase
    endfunction

    // =====================================================================
    // State
    rws_pkg::rws_state_s st_q;
    rws_pkg::rws_state_s st_d;

    logic ext_n_s;
    logic hold;
    logic setup;
    logic access;
    logic wr_acc;
    logic rd_acc;
    rws_pkg::rws_sel_e sel_setup;
    rws_pkg::rws_sel_e sel_acc;

    // =====================================================================
    // External reset synchroniser
    // Synchronised reset release
    rws_sync #(
        .W       (1),
        .RST_VAL (1'b0)
    ) u_ext_sync (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .d   (EXTERNAL_RESET_IN_N),
        .q   (ext_n_s)
    );

    // =====================================================================
    // Bus phases
    assign setup     = PSEL & ~PENABLE;
    assign access    = PSEL & PENABLE & st_q.pready;
    assign wr_acc    = access & PWRITE;
    assign rd_acc    = access & ~PWRITE;
    assign sel_setup = reg_sel(PADDR);
    assign sel_acc   = reg_sel(PADDR);

    // Hold while pin low or power-on count runs
    assign hold = (st_q.por_cnt != '0) | ~ext_n_s;

    // =====================================================================
    // Next state
    always_comb begin
        st_d         = st_q;
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;

        if (st_q.por_cnt != '0) begin
            st_d.por_cnt = st_q.por_cnt - 1'b1;
        end
        st_d.int_rst = hold;

        st_d.link.auto_mdix_en = CROSSOVER_AUTO_STRAP;

        if (st_q.int_rst) begin
            st_d.read_done = 1'b0;
            st_d.asleep    = 1'b0;
            st_d.wake_en   = 1'b0;
            st_d.wake_pol  = 1'b0;
            st_d.wake_od   = 1'b0;
            st_d.wake_evt  = 1'b0;
            st_d.wr_drop   = 1'b0;
            st_d.prdata    = 32'h0000_0000;
            if (!hold) begin
                st_d.strap_speed = SPEED_STRAP_IN;
                st_d.link.speed_100   = SPEED_STRAP_IN;
                st_d.link.full_duplex = 1'b0;
                st_d.link.autoneg_en  = SPEED_STRAP_IN;
            end
        end else begin
            // Setup phase prepares the answer; access completes one cycle later
            if (setup) begin
                st_d.pready  = 1'b1;
                st_d.pslverr = (sel_setup == rws_pkg::SEL_NONE);
                st_d.prdata  = 32'h0000_0000;
                if (!st_q.asleep) begin
                    case (sel_setup)
                        rws_pkg::SEL_ORDER: begin
                            st_d.prdata = rws_pkg::ORDER_VAL;
                        end
                        rws_pkg::SEL_CTRL: begin
                            st_d.prdata[rws_pkg::CTRL_WAKE_EN]  = st_q.wake_en;
                            st_d.prdata[rws_pkg::CTRL_WAKE_POL] = st_q.wake_pol;
                            st_d.prdata[rws_pkg::CTRL_WAKE_OD]  = st_q.wake_od;
                            st_d.prdata[rws_pkg::CTRL_SLEEP]    = st_q.asleep;
                        end
                        rws_pkg::SEL_STATUS: begin
                            st_d.prdata[rws_pkg::ST_ASLEEP]    = st_q.asleep;
                            st_d.prdata[rws_pkg::ST_READ_DONE] = st_q.read_done;
                            st_d.prdata[rws_pkg::ST_WAKE_EVT]  = st_q.wake_evt;
                            st_d.prdata[rws_pkg::ST_WR_DROP]   = st_q.wr_drop;
                            st_d.prdata[rws_pkg::ST_SPEED_100] = st_q.link.speed_100;
                            st_d.prdata[rws_pkg::ST_FULL_DUP]  = st_q.link.full_duplex;
                            st_d.prdata[rws_pkg::ST_AUTONEG]   = st_q.link.autoneg_en;
                            st_d.prdata[rws_pkg::ST_AUTO_MDIX] = st_q.link.auto_mdix_en;
                            st_d.prdata[rws_pkg::ST_STRAP]     = st_q.strap_speed;
                        end
                        default: begin
                            st_d.prdata = 32'h0000_0000;
                        end
                    endcase
                end
            end

            // Keep the answer standing through the access cycle
            if (access) begin
                st_d.prdata = st_q.prdata;
            end

            // A sleeping device counts no reads, so the wake write is always
            // followed by a fresh read before any write lands
            if (rd_acc && !st_q.asleep) begin
                st_d.read_done = 1'b1;
            end

            if (wr_acc) begin
                if (st_q.asleep) begin
                    st_d.asleep    = 1'b0;
                    st_d.read_done = 1'b0;
                end else if (!st_q.read_done) begin
                    st_d.wr_drop = 1'b1;
                end else begin
                    case (sel_acc)
                        rws_pkg::SEL_CTRL: begin
                            st_d.wake_en  = PWDATA[rws_pkg::CTRL_WAKE_EN];
                            st_d.wake_pol = PWDATA[rws_pkg::CTRL_WAKE_POL];
                            st_d.wake_od  = PWDATA[rws_pkg::CTRL_WAKE_OD];
                            if (PWDATA[rws_pkg::CTRL_SLEEP]) begin
                                st_d.asleep    = 1'b1;
                                st_d.read_done = 1'b0;
                            end
                        end
                        rws_pkg::SEL_STATUS: begin
                            if (PWDATA[rws_pkg::ST_WAKE_EVT]) begin
                                st_d.wake_evt = 1'b0;
                            end
                            if (PWDATA[rws_pkg::ST_WR_DROP]) begin
                                st_d.wr_drop = 1'b0;
                            end
                        end
                        default: begin
                            st_d.wake_evt = st_d.wake_evt;
                        end
                    endcase
                end
            end

            // Enabled event latches; set beats clear
            if (WAKE_EVENT_IN && st_q.wake_en) begin
                st_d.wake_evt = 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            st_q <= rws_pkg::STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // Wake indicator pin
    // Indicator drive
    rws_wake_drv u_wake_drv (
        .clk        (SYS_CLK),
        .rst        (SYS_RST),
        .active     (st_q.wake_en & st_q.wake_evt),
        .pol_high   (st_q.wake_pol),
        .open_drain (st_q.wake_od),
        .pin_o      (WAKE_INDICATOR_OUT_O),
        .pin_oe     (WAKE_INDICATOR_OUT_OE)
    );

    // =====================================================================
    // Outputs
    assign PRDATA         = st_q.prdata;
    assign PREADY         = st_q.pready;
    assign PSLVERR        = st_q.pslverr;
    assign INTERNAL_RESET = st_q.int_rst;
    assign POWER_SAVE     = st_q.asleep;
    assign LINK_CFG       = st_q.link;

endmodule

`default_nettype wire

/* File: rtl/rws_pkg.sv */
// Purpose: Shared constants and types for the reset, wake and strap control block
// Assumes: One 50 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
`default_nettype none

package rws_pkg;

    // =====================================================================
    // Timing
    localparam int CLK_HZ       = 50_000_000;
    localparam int REF_HZ       = 25_000_000;
    localparam int POR_TIME_NS  = 2000;
    // Least time: round up to whole cycles
    localparam int POR_CYCLES   = (POR_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int POR_W        = 8;

    // =====================================================================
    // Register map
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFF_ORDER   = 8'h00;
    localparam logic [7:0]  OFF_CTRL    = 8'h04;
    localparam logic [7:0]  OFF_STATUS  = 8'h08;
    // Arbitrary value, fixed pattern for byte-order checks
    localparam logic [31:0] ORDER_VAL   = 32'h0F1E_2D3C;

    // Control register fields
    localparam int CTRL_WAKE_EN  = 0;
    localparam int CTRL_WAKE_POL = 1;
    localparam int CTRL_WAKE_OD  = 2;
    localparam int CTRL_SLEEP    = 3;

    // Status register fields
    localparam int ST_ASLEEP     = 0;
    localparam int ST_READ_DONE  = 1;
    localparam int ST_WAKE_EVT   = 2;
    localparam int ST_WR_DROP    = 3;
    localparam int ST_SPEED_100  = 4;
    localparam int ST_FULL_DUP   = 5;
    localparam int ST_AUTONEG    = 6;
    localparam int ST_AUTO_MDIX  = 7;
    localparam int ST_STRAP      = 8;

    // =====================================================================
    // Types
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_ORDER,
        SEL_CTRL,
        SEL_STATUS
    } rws_sel_e;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic autoneg_en;
        logic auto_mdix_en;
    } rws_link_s;

    typedef struct packed {
        logic [POR_W-1:0] por_cnt;
        logic             int_rst;
        logic             read_done;
        logic             asleep;
        logic             wake_en;
        logic             wake_pol;
        logic             wake_od;
        logic             wake_evt;
        logic             wr_drop;
        logic             strap_speed;
        rws_link_s        link;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } rws_state_s;

    localparam rws_link_s LINK_RST = '{
        speed_100: 1'b0, full_duplex: 1'b0, autoneg_en: 1'b0, auto_mdix_en: 1'b0
    };

    localparam rws_state_s STATE_RST = '{
        por_cnt:     POR_W'(POR_CYCLES),
        int_rst:     1'b1,
        read_done:   1'b0,
        asleep:      1'b0,
        wake_en:     1'b0,
        wake_pol:    1'b0,
        wake_od:     1'b0,
        wake_evt:    1'b0,
        wr_drop:     1'b0,
        strap_speed: 1'b0,
        link:        LINK_RST,
        pready:      1'b0,
        pslverr:     1'b0,
        prdata:      32'h0000_0000
    };

endpackage

`default_nettype wire

/* File: rtl/rws_sync.sv */
// Purpose: Two-flop synchroniser for level signals
// Assumes: Destination clock is the system clock
// Notes:   First stage feeds only the second stage
`default_nettype none

module rws_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // =====================================================================
    // Stages
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_q[i] <= RST_VAL[i];
                    sync_q[i] <= RST_VAL[i];
                end else begin
                    meta_q[i] <= d[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign q = sync_q;

endmodule

`default_nettype wire

/* File: rtl/rws_wake_drv.sv */
// Purpose: Wake indicator pin driver with programmable polarity and buffer type
// Assumes: Pin resolved from output and enable outside the design
// Notes:   Output and enable come straight from flip-flops
`default_nettype none

module rws_wake_drv (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic active,
    input  wire logic pol_high,
    input  wire logic open_drain,
    // Pin
    output logic      pin_o,
    output logic      pin_oe
);

    // =====================================================================
    // Driver
    logic lvl;
    logic o_q;
    logic oe_q;

    assign lvl = pol_high ? active : ~active;

    always_ff @(posedge clk) begin
        if (rst) begin
            o_q  <= 1'b0;
            oe_q <= 1'b0;
        end else if (open_drain) begin
            // Open drain can only pull low; a high level is left to the pull-up
            o_q  <= 1'b0;
            oe_q <= ~lvl;
        end else begin
            o_q  <= lvl;
            oe_q <= 1'b1;
        end
    end

    assign pin_o  = o_q;
    assign pin_oe = oe_q;

endmodule

`default_nettype wire

/* File: verif/rws_top_chk.sv */
// Purpose: Port-level checks for the reset, wake and strap block
// Assumes: Bound onto rws_top from the bench top
// Notes:   Single clock domain
`default_nettype none

module rws_chk (
    // Clock and reset
    input  wire logic               SYS_CLK,
    input  wire logic               SYS_RST,
    // Inputs watched
    input  wire logic               EXTERNAL_RESET_IN_N,
    input  wire logic               CROSSOVER_AUTO_STRAP,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    // Outputs watched
    input  wire logic               PREADY,
    input  wire logic               INTERNAL_RESET,
    input  wire logic               POWER_SAVE,
    input  wire rws_pkg::rws_link_s LINK_CFG
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    // ====================================================================
    // Properties
    a_por_holds: assert property (
        $fell(SYS_RST) |-> INTERNAL_RESET [*8])
        else $error("internal reset released too early after power-on");
    a_ext_resets: assert property (
        !EXTERNAL_RESET_IN_N [*4] |=> INTERNAL_RESET && !POWER_SAVE)
        else $error("external reset did not reset the block");
    a_apb_ready: assert property (
        PSEL && !PENABLE && !INTERNAL_RESET |=> PREADY)
        else $error("no ready in access cycle");
    a_mdix_follow: assert property (
        !INTERNAL_RESET && $past(!INTERNAL_RESET)
        |-> LINK_CFG.auto_mdix_en == $past(CROSSOVER_AUTO_STRAP))
        else $error("auto crossover does not follow its strap");
    a_speed_held: assert property (
        !INTERNAL_RESET && $past(!INTERNAL_RESET) |-> $stable(LINK_CFG.speed_100))
        else $error("captured speed changed outside reset");
    a_half_duplex: assert property (
        !LINK_CFG.full_duplex)
        else $error("full duplex selected by default");
    a_speed_autoneg: assert property (
        LINK_CFG.speed_100 == LINK_CFG.autoneg_en)
        else $error("speed and autoneg defaults disagree");
    a_wake_by_write: assert property (
        $fell(POWER_SAVE) && !INTERNAL_RESET && $past(EXTERNAL_RESET_IN_N)
        |-> $past(PSEL && PENABLE && PWRITE))
        else $error("left sleep without a host write");
endmodule

`default_nettype wire

/* File: verif/rws_board.sv */
// Purpose: Board side of the wake indicator pin
// Assumes: Weak pull-up on the board net
// Notes:   Released pin reads high, never the last driven value
`default_nettype none

module rws_board (
    // Pin from the device
    input  wire logic pin_o,
    input  wire logic pin_oe,
    // Level on the board net
    output logic      level
);
    timeunit 1ns;
    timeprecision 1ps;

    assign level = pin_oe ? pin_o : 1'b1;
endmodule

`default_nettype wire

/* File: verif/test_reset_wake_strap_control.sv */
// Purpose: Directed bench for the reset, wake and strap block
// Assumes: APB master tasks, zero to 18 wait states tolerated
// Notes:   Board pull-up model resolves the wake pin
`default_nettype none

module test_reset_wake_strap_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic               sys_clk     = 1'b0;
    logic               sys_rst     = 1'b1;
    logic               ext_rst_n   = 1'b1;
    logic               speed_strap = 1'b1;
    logic               cross_strap = 1'b1;
    logic               wake_evt    = 1'b0;
    logic               psel        = 1'b0;
    logic               penable     = 1'b0;
    logic               pwrite      = 1'b0;
    logic [7:0]         paddr       = 8'h00;
    logic [31:0]        pwdata      = 32'h0000_0000;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               wake_o;
    logic               wake_oe;
    logic               int_rst;
    logic               power_save;
    logic               pin_level;
    rws_pkg::rws_link_s link_cfg;
    int                 fail_count  = 0;
    int                 n_checks    = 0;
    int                 cnt;
    logic [31:0]        rd;
    logic               err;

    always #10 sys_clk = ~sys_clk;

    rws_top dut (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .EXTERNAL_RESET_IN_N(ext_rst_n),
        .SPEED_STRAP_IN(speed_strap), .CROSSOVER_AUTO_STRAP(cross_strap),
        .WAKE_EVENT_IN(wake_evt), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .WAKE_INDICATOR_OUT_O(wake_o),
        .WAKE_INDICATOR_OUT_OE(wake_oe), .INTERNAL_RESET(int_rst),
        .POWER_SAVE(power_save), .LINK_CFG(link_cfg)
    );

    rws_board u_board (.pin_o(wake_o), .pin_oe(wake_oe), .level(pin_level));

    // ====================================================================
    // Tasks
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", fail_count, n_checks);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    // Request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk32(rd, e);
    endtask

    task automatic wait_rst_low(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (int_rst !== 1'b0 && n < 300);
    endtask

    task automatic pulse_evt();
        @(posedge sys_clk);
        wake_evt <= 1'b1;
        @(posedge sys_clk);
        wake_evt <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // ====================================================================
    // Tests
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wait_rst_low(cnt);
        chk1(cnt > 95 && cnt < 110, 1'b1);
        chk32(32'(link_cfg), 32'h0000_000B);
        $display("test power-on done");
        // Write before first read must be lost
        apb(1'b1, rws_pkg::OFF_CTRL, 32'h0000_0003);
        rdc(rws_pkg::OFF_ORDER, rws_pkg::ORDER_VAL);
        rdc(rws_pkg::OFF_CTRL, 32'h0000_0000);
        rdc(rws_pkg::OFF_STATUS, 32'h0000_01DA);
        rdc(8'h0C, 32'h0000_0000);
        chk1(err, 1'b1);
        apb(1'b1, rws_pkg::OFF_STATUS, 32'h0000_0008);
        apb(1'b1, rws_pkg::OFF_CTRL, 32'h0000_0003);
        rdc(rws_pkg::OFF_CTRL, 32'h0000_0003);
        $display("test first read done");
        chk1(pin_level, 1'b0);
        pulse_evt();
        chk1(pin_level, 1'b1);
        rdc(rws_pkg::OFF_STATUS, 32'h0000_01D6);
        apb(1'b1, rws_pkg::OFF_STATUS, 32'h0000_0004);
        repeat (3) @(posedge sys_clk);
        chk1(pin_level, 1'b0);
        apb(1'b1, rws_pkg::OFF_CTRL, 32'h0000_0005);
        cross_strap <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk1(wake_oe, 1'b0);
        chk1(link_cfg.auto_mdix_en, 1'b0);
        pulse_evt();
        chk1(wake_oe, 1'b1);
        chk1(pin_level, 1'b0);
        $display("test wake pin done");
        apb(1'b1, rws_pkg::OFF_CTRL, 32'h0000_000D);
        repeat (2) @(posedge sys_clk);
        chk1(power_save, 1'b1);
        pulse_evt();
        rdc(rws_pkg::OFF_ORDER, 32'h0000_0000);
        chk1(power_save, 1'b1);
        // Waking write aimed at the byte-order register, data ignored
        apb(1'b1, rws_pkg::OFF_ORDER, 32'h5A5A_A5A5);
        repeat (2) @(posedge sys_clk);
        chk1(power_save, 1'b0);
        apb(1'b1, rws_pkg::OFF_CTRL, 32'h0000_0000);
        apb(1'b0, rws_pkg::OFF_CTRL, 32'h0000_0000);
        chk32(rd & 32'h0000_0007, 32'h0000_0005);
        $display("test sleep done");
        @(posedge sys_clk);
        ext_rst_n   <= 1'b0;
        speed_strap <= 1'b0;
        cross_strap <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk1(int_rst, 1'b1);
        ext_rst_n <= 1'b1;
        wait_rst_low(cnt);
        chk32(32'(link_cfg), 32'h0000_0001);
        chk1(pin_level, 1'b1);
        rdc(rws_pkg::OFF_CTRL, 32'h0000_0000);
        $display("test external reset done");
        test_done();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #100us;
        fail_count++;
        test_done();
    end
endmodule

bind rws_top rws_chk u_chk (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .EXTERNAL_RESET_IN_N(EXTERNAL_RESET_IN_N),
    .CROSSOVER_AUTO_STRAP(CROSSOVER_AUTO_STRAP), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PREADY(PREADY), .INTERNAL_RESET(INTERNAL_RESET),
    .POWER_SAVE(POWER_SAVE), .LINK_CFG(LINK_CFG)
);

`default_nettype wire
